// ### design/pmc_defs.vh
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// Register addresses, 16-bit registers on 2-byte steps
`define PMC_ADDR_W 32
`define PMC_DATA_W 16
`define PMC_NUM_PINS 5
`define PMC_PORT3_PIN5_MODE 32'h50003058
`define PMC_PORT3_PIN6_MODE 32'h5000305A
`define PMC_PORT3_PIN7_MODE 32'h5000305C
`define PMC_PORT4_PIN0_MODE 32'h5000305E
`define PMC_PORT4_PIN1_MODE 32'h50003060
`define PMC_BASE_ADDR 32'h50003058
`define PMC_ADDR_STEP 32'h00000002

// Field positions
`define PMC_OD_BIT 10
`define PMC_DIR_HI 9
`define PMC_DIR_LO 8
`define PMC_FUNC_HI 5
`define PMC_FUNC_LO 0
`define PMC_WR_MASK 16'h073F

// Reset values
`define PMC_OD_RST 1'h0
`define PMC_DIR_RST 2'h2
`define PMC_FUNC_RST 6'h00

// Direction and resistor codes
`define PMC_DIR_IN_NONE 2'h0
`define PMC_DIR_IN_PU 2'h1
`define PMC_DIR_IN_PD 2'h2
`define PMC_DIR_OUT 2'h3

// Function code for the converter input; encoding defined elsewhere
`define PMC_FUNC_ADC_DEF 6'h0F

`endif

// ### design/pmc_pad_mode_config.v
`timescale 1ns/1ps
`include "pmc_defs.vh"

module pmc_pad_mode_config #(
   parameter [5:0] FUNC_ADC = `PMC_FUNC_ADC_DEF
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [31:0] bus_addr,
   input wire [15:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output wire [15:0] bus_rdata,
   output wire [4:0] pad_open_drain,
   output wire [4:0] pad_output_en,
   output wire [4:0] pad_pullup_en,
   output wire [4:0] pad_pulldown_en,
   output wire [4:0] pad_analog_en,
   output wire [29:0] pad_function
);

////////////////////////////////////////////////////////////////////////////////
// Sizes and constants

localparam integer NUM_PINS = `PMC_NUM_PINS;
localparam [15:0] WR_MASK = `PMC_WR_MASK;
localparam [15:0] MODE_RST = {5'h00, `PMC_OD_RST, `PMC_DIR_RST, 2'h0, `PMC_FUNC_RST};
localparam [1:0] DIR_IN_PU = `PMC_DIR_IN_PU;
localparam [1:0] DIR_IN_PD = `PMC_DIR_IN_PD;
localparam [1:0] DIR_OUT = `PMC_DIR_OUT;

////////////////////////////////////////////////////////////////////////////////
// Nets gathered from the per-pin slices

// One address hit per pin, never more than one at a time
wire [4:0] hit_w;

// All mode words side by side, pin i at [16i+15:16i]
wire [79:0] mode_flat;

////////////////////////////////////////////////////////////////////////////////
// Read path

reg [15:0] rdata_r;
reg [15:0] rdata_nxt;
integer k;

// Hits are one-hot, so an OR of gated words acts as the mux
always @* begin
   rdata_nxt = 16'h0000;
   if (bus_rd) begin
      for (k = 0; k < NUM_PINS; k = k + 1) begin
         if (hit_w[k]) begin
            rdata_nxt = rdata_nxt | mode_flat[k*16 +: 16];
         end
      end
   end
end

// Read data stands one cycle and then falls back to zero
always @(posedge ref_clk or negedge rst_n) begin
   if (!rst_n) begin
      rdata_r <= 16'h0000;
   end else begin
      rdata_r <= rdata_nxt;
   end
end

assign bus_rdata = rdata_r;

////////////////////////////////////////////////////////////////////////////////
// Per-pin mode register and pad controls

genvar g;
generate
   for (g = 0; g < NUM_PINS; g = g + 1) begin : pin
      localparam [31:0] PIN_ADDR = `PMC_BASE_ADDR + g * `PMC_ADDR_STEP;

      reg [15:0] mode_r;
      reg [15:0] mode_nxt;
      reg od_r;
      reg oe_r;
      reg pu_r;
      reg pd_r;
      reg an_r;
      reg [5:0] fn_r;
      wire [1:0] dir;
      wire [5:0] func;
      wire analog;

      // Full address compare; unmapped words neither write nor read
      assign hit_w[g] = (bus_addr == PIN_ADDR);

      assign dir = mode_r[`PMC_DIR_HI:`PMC_DIR_LO];
      assign func = mode_r[`PMC_FUNC_HI:`PMC_FUNC_LO];
      assign analog = (func == FUNC_ADC);

      assign mode_flat[g*16 +: 16] = mode_r;

      /////////////////////////////////////////////////////////////////////////
      // Mode word

      always @* begin
         mode_nxt = mode_r;
         if (bus_wr && hit_w[g]) begin
            mode_nxt = bus_wdata & WR_MASK;
         end
      end

      // Masked on write, so reserved bits read zero for free
      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            mode_r <= MODE_RST;
         end else begin
            mode_r <= mode_nxt;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // Pad controls, one cycle behind the mode word

      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            od_r <= 1'b0;
         end else begin
            od_r <= mode_r[`PMC_OD_BIT];
         end
      end

      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            oe_r <= 1'b0;
         end else if (analog) begin
            oe_r <= 1'b0;
         end else begin
            oe_r <= (dir == DIR_OUT);
         end
      end

      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            pu_r <= 1'b0;
         end else if (analog) begin
            pu_r <= 1'b0;
         end else begin
            pu_r <= (dir == DIR_IN_PU);
         end
      end

      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            pd_r <= 1'b1;
         end else if (analog) begin
            pd_r <= 1'b0;
         end else begin
            pd_r <= (dir == DIR_IN_PD);
         end
      end

      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            an_r <= 1'b0;
         end else begin
            an_r <= analog;
         end
      end

      // function select
      // Passed on raw; its decoding lives with the peripherals
      always @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            fn_r <= 6'h00;
         end else begin
            fn_r <= func;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // Pad ports, each bit straight from its flop

      assign pad_open_drain[g] = od_r;
      assign pad_output_en[g] = oe_r;
      assign pad_pullup_en[g] = pu_r;
      assign pad_pulldown_en[g] = pd_r;
      assign pad_analog_en[g] = an_r;
      assign pad_function[g*6 +: 6] = fn_r;
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Limitation: a write and the pad change are two edges apart, so
// mode_r leads the pad by one cycle, but bus_rdata shows the new word no earlier than the pad.

endmodule

// ### sim/pmc_assertions.sv
`timescale 1ns/1ps
module pmc_chk (
   input wire ref_clk,
   input wire rst_n,
   input wire [31:0] bus_addr,
   input wire [15:0] bus_wdata,
   input wire bus_wr,
   input wire [15:0] bus_rdata,
   input wire [4:0] pad_open_drain,
   input wire [4:0] pad_output_en,
   input wire [4:0] pad_pullup_en,
   input wire [4:0] pad_pulldown_en,
   input wire [4:0] pad_analog_en,
   input wire [29:0] pad_function
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire w = bus_wr && bus_addr == 32'h50003058;
   wire d = w && bus_wdata[5:0] != 6'h0F;
   property p_od; w |-> ##2 pad_open_drain[0] == $past(bus_wdata[10], 2); endproperty
   a_od: assert property (p_od) else $error("drive style");
   property p_pu; d && bus_wdata[9:8] == 2'h1 |-> ##2 pad_pullup_en[0] && !pad_pulldown_en[0];
   endproperty
   a_pu: assert property (p_pu) else $error("pull-up");
   property p_pd; d && bus_wdata[9:8] == 2'h2 |-> ##2 pad_pulldown_en[0] && !pad_output_en[0];
   endproperty
   a_pd: assert property (p_pd) else $error("pull-down");
   property p_out; d && bus_wdata[9:8] == 2'h3 |-> ##2 pad_output_en[0] && !pad_pullup_en[0];
   endproperty
   a_out: assert property (p_out) else $error("output");
   property p_adc; w && !d |-> ##2 pad_analog_en[0] &&
      !(pad_output_en[0] | pad_pulldown_en[0] | pad_pullup_en[0]);
   endproperty
   a_adc: assert property (p_adc) else $error("analog");
   property p_rsv; (bus_rdata & 16'hF8C0) == 16'h0000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved");
   property p_fn; w |-> ##2 pad_function[5:0] == $past(bus_wdata[5:0], 2); endproperty
   a_fn: assert property (p_fn) else $error("function select");
endmodule
bind pmc_pad_mode_config pmc_chk u_chk (.*);

// ### sim/pad_mode_config_tb.sv
`timescale 1ns/1ps
module pad_mode_config_tb;
   reg ref_clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0;
   reg [31:0] bus_addr = 0, r;
   reg [15:0] bus_wdata = 0, v, d, m [0:5];
   wire [15:0] bus_rdata;
   wire [4:0] od, oe, pu, pd, an;
   wire [29:0] fn;
   integer failures = 0, checks = 0, i, k;
   pmc_pad_mode_config dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .pad_open_drain(od), .pad_output_en(oe), .pad_pullup_en(pu), .pad_pulldown_en(pd),
      .pad_analog_en(an), .pad_function(fn));
   initial forever #12.5 ref_clk = ~ref_clk;
   function [15:0] pe(input [15:0] r);
      pe = {r[10], r[5:0] == 6'h0F ? 4'h1 : {r[9:8] == 3, r[9:8] == 1, r[9:8] == 2, 1'b0}};
   endfunction
   // Called at an edge: one-cycle strobe, read data taken while it stands
   task acc(input w, input [2:0] n, input [15:0] x);
      begin
         bus_wr <= w;
         bus_rd <= !w;
         bus_addr <= 32'h50003058 + 2 * n;
         bus_wdata <= x;
         @(posedge ref_clk);
         bus_wr <= 0;
         bus_rd <= 0;
         #1 v = bus_rdata;
         @(posedge ref_clk);
      end
   endtask
   task chk(input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED reg %0d exp %h got %h", k, e, g);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      k = $urandom(16);
      for (i = 0; i < 6; i = i + 1) m[i] = i < 5 ? 16'h0200 : 16'h0000;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1;
      // Index 5 lands on the unmapped word
      for (i = 0; i < 96; i = i + 1) begin
         k = i % 6;
         r = $urandom;
         d = r[15:0];
         if (i % 5 == 1) d[5:0] = 6'h0F;
         if (i >= 6) acc(1, k, d);
         if (i >= 6 && k < 5) m[k] = d & 16'h073F;
         acc(0, k, 0);
         chk(m[k], v);
         if (k < 5) chk(pe(m[k]), {od[k], oe[k], pu[k], pd[k], an[k]});
         if (k < 5) chk({10'h000, m[k][5:0]}, {10'h000, fn[k*6 +: 6]});
      end
      // Reset again in mid-run: every word back to input with pull-down
      rst_n <= 0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1;
      for (k = 0; k < 5; k = k + 1) begin
         acc(0, k, 0);
         chk(16'h0200, v);
         chk(pe(16'h0200), {od[k], oe[k], pu[k], pd[k], an[k]});
      end
      print_verdict;
   end
endmodule
